// ==== rtl/i2cswp_pkg.sv ====
package i2cswp_pkg;
   // Fixed upper part of the slave address, bits 6 down to 2
   localparam logic [4:0] FIXED_ADDR     = 5'h1D;
   localparam int         FIXED_HI       = 6;
   localparam int         FIXED_LO       = 2;
   // Byte and command byte layout
   localparam logic [2:0] BIT_LAST       = 3'h7;
   localparam logic [2:0] BIT_ZERO       = 3'h0;
   localparam int         OP_HI          = 7;
   localparam int         OP_LO          = 5;
   localparam int         VAL_HI         = 4;
   localparam logic [2:0] OP_MARGIN      = 3'h1;
   localparam logic [2:0] OP_WATCHDOG    = 3'h3;
   localparam logic [4:0] VAL_NULL       = 5'h00;
   localparam int         MARGIN_SEL     = 4;
   localparam logic [3:0] MARGIN_NOMINAL = 4'h0;
   localparam logic [4:0] WD_OFF         = 5'h00;

   // Transfer phases
   typedef enum logic [2:0] {
      I2CSWP_IDLE,
      I2CSWP_ADDR,
      I2CSWP_ACK,
      I2CSWP_DATA,
      I2CSWP_WAIT
   } i2cswp_phase_type;

   // Sampled bus lines after two flip-flops
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cswp_lines_type;

   // Settings driven out to the supply
   typedef struct packed {
      logic [3:0] ldoMargin;
      logic [3:0] swMargin;
      logic [4:0] watchdog;
      logic       strobe;
   } i2cswp_cfg_type;
endpackage : i2cswp_pkg

// ==== rtl/i2cswp_sync.sv ====
module i2cswp_sync
(
   input  wire  logic clock,
   input  wire  logic sys_rst,
   input  wire  logic enable,
   input  wire  logic asyncIn,
   output logic       syncOut
);
   logic [1:0] stage_q; // First stage read only by second

   // Two flip-flop level synchroniser
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         stage_q <= 2'h3;
      else if (enable)
         stage_q <= {stage_q[0], asyncIn};
   end

   assign syncOut = stage_q[1];
endmodule : i2cswp_sync

// ==== rtl/i2c_slave_write_port.sv ====
// Functional notes
// - Ack matching write address after start
// - Compare address bits six to two fixed
// - Low address bits follow strap levels
// - Clock strap sets sync pin direction
// - Four devices need distinct strap combinations
// - Accept and ack data after address
// - Slave drives only acknowledge bits
// - Byte is operation plus value field
// - First command opens each operation
module i2c_slave_write_port
(
   input  wire  logic                        clock,
   input  wire  logic                        sys_rst,
   input  wire  logic                        enable,
   input  wire  logic                        sclIn,
   input  wire  logic                        sdaIn,
   output logic                              sdaOut,
   output logic                              sdaOe,
   input  wire  logic                        clockSelectStrap,
   input  wire  logic                        busIdStrap,
   input  wire  logic                        oscClockIn,
   output logic                              oscillatorSyncPinOut,
   output logic                              oscillatorSyncPinOe,
   output logic                              syncClockOut,
   output i2cswp_pkg::i2cswp_cfg_type        cfgOut
);
   ////////////////////////////////////////////////////////////////////////
   // Synchronisers
   i2cswp_pkg::i2cswp_lines_type lines; // Synchronised bus lines
   logic                         oscSync; // Local oscillator, synced
   logic                         extSync; // External sync clock, synced

   i2cswp_sync uSyncScl
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (sclIn),
      .syncOut (lines.scl)
   );
   i2cswp_sync uSyncSda
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (sdaIn),
      .syncOut (lines.sda)
   );
   i2cswp_sync uSyncOsc
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (oscClockIn),
      .syncOut (oscSync)
   );
   // Shared pad: the sync pin reads back through the oscillator input
   logic oscSyncPinIn; // Pin level for input mode
   logic selSync;      // Clock-select strap, synced
   logic idSync;       // Bus-id strap, synced
   assign oscSyncPinIn = oscClockIn;
   i2cswp_sync uSyncExt
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (oscSyncPinIn),
      .syncOut (extSync)
   );
   // Straps are pins as well, so they pass the same two stages
   i2cswp_sync uSyncSel
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (clockSelectStrap),
      .syncOut (selSync)
   );
   i2cswp_sync uSyncId
   (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (enable),
      .asyncIn (busIdStrap),
      .syncOut (idSync)
   );

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      i2cswp_pkg::i2cswp_lines_type prev;  // Lines one cycle earlier
      i2cswp_pkg::i2cswp_phase_type phase; // Transfer phase
      logic [2:0]                   bitCnt; // Bit index in byte
      logic [7:0]                   shift;  // Incoming byte
      logic                         ackDrive; // Pulling data low
      logic                         addrPhase; // Ack belongs to address
      logic [2:0]                   armedOp; // Operation after first cmd
      logic                         armed;   // First command seen
      logic                         upperSelectBit;
      logic                         lowerSelectBit;
      logic                         syncOutMode; // Pin is an output
      logic                         syncClk;     // Registered sync clock
      i2cswp_pkg::i2cswp_cfg_type   cfg;
   } i2cswp_state_type;

   i2cswp_state_type state_q; // Registered state
   i2cswp_state_type state_d; // Next state
   logic             sclRise; // Clock edges and bus events
   logic             sclFall;
   logic             startCond;
   logic             stopCond;
   logic [6:0]       myAddr;  // Own address

   assign sclRise   = lines.scl & ~state_q.prev.scl;
   assign sclFall   = ~lines.scl & state_q.prev.scl;
   // Data edges while clock stays high mark start and stop
   assign startCond = lines.scl & state_q.prev.scl
                      & state_q.prev.sda & ~lines.sda;
   assign stopCond  = lines.scl & state_q.prev.scl
                      & ~state_q.prev.sda & lines.sda;
   assign myAddr    = {i2cswp_pkg::FIXED_ADDR, state_q.upperSelectBit,
                       state_q.lowerSelectBit};

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      state_d            = state_q;
      state_d.prev       = lines;
      state_d.cfg.strobe = 1'h0;
      // Straps followed through synchronisers; they are static in use,
      // so the short lag after reset release does no harm
      state_d.upperSelectBit = selSync;
      state_d.lowerSelectBit = idSync;
      state_d.syncOutMode    = selSync;
      // Sync pin: drive own oscillator or follow external clock
      state_d.syncClk = state_q.syncOutMode ? oscSync : extSync;
      if (startCond)
      begin
         // Repeated start also restarts address phase
         state_d.phase    = i2cswp_pkg::I2CSWP_ADDR;
         state_d.bitCnt   = i2cswp_pkg::BIT_ZERO;
         state_d.ackDrive = 1'h0;
         state_d.armed    = 1'h0;
      end
      else if (stopCond)
      begin
         state_d.phase    = i2cswp_pkg::I2CSWP_IDLE;
         state_d.ackDrive = 1'h0;
      end
      else
      begin
         case (state_q.phase)
            i2cswp_pkg::I2CSWP_ADDR,
            i2cswp_pkg::I2CSWP_DATA:
            begin
               if (sclRise)
               begin
                  state_d.shift  = {state_q.shift[6:0], lines.sda};
                  state_d.bitCnt = state_q.bitCnt + 3'h1;
                  if (state_q.bitCnt == i2cswp_pkg::BIT_LAST)
                     state_d.phase = i2cswp_pkg::I2CSWP_ACK;
                  state_d.addrPhase =
                     (state_q.phase == i2cswp_pkg::I2CSWP_ADDR);
               end
            end
            i2cswp_pkg::I2CSWP_ACK:
            begin
               // Byte complete; decide on fall of eighth clock
               if (sclFall && !state_q.ackDrive)
               begin
                  if (state_q.addrPhase)
                  begin
                     // Write only: read requests are not answered
                     if (state_q.shift[7:1] == myAddr
                         && !state_q.shift[0])
                        state_d.ackDrive = 1'h1;
                     else
                        state_d.phase = i2cswp_pkg::I2CSWP_WAIT;
                  end
                  else
                  begin
                     state_d.ackDrive = 1'h1;
                     // Operation and value fields
                     if (state_q.shift[i2cswp_pkg::VAL_HI:0]
                         == i2cswp_pkg::VAL_NULL
                         && !state_q.armed)
                     begin
                        state_d.armed   = 1'h1;
                        state_d.armedOp =
                           state_q.shift[i2cswp_pkg::OP_HI:
                                         i2cswp_pkg::OP_LO];
                     end
                     else if (state_q.armed && state_q.armedOp
                              == state_q.shift[i2cswp_pkg::OP_HI:
                                               i2cswp_pkg::OP_LO])
                     begin
                        state_d.cfg.strobe = 1'h1;
                        // Margining stays armed for the other output
                        if (state_q.armedOp == i2cswp_pkg::OP_MARGIN)
                        begin
                           if (state_q.shift[i2cswp_pkg::MARGIN_SEL])
                              state_d.cfg.swMargin =
                                 state_q.shift[i2cswp_pkg::MARGIN_SEL-1:0];
                           else
                              state_d.cfg.ldoMargin =
                                 state_q.shift[i2cswp_pkg::MARGIN_SEL-1:0];
                        end
                        else if (state_q.armedOp
                                 == i2cswp_pkg::OP_WATCHDOG)
                           state_d.cfg.watchdog =
                              state_q.shift[i2cswp_pkg::VAL_HI:0];
                     end
                  end
               end
               else if (sclFall && state_q.ackDrive)
               begin
                  // Ack bit done: release line, next byte
                  state_d.ackDrive = 1'h0;
                  state_d.phase    = i2cswp_pkg::I2CSWP_DATA;
                  state_d.bitCnt   = i2cswp_pkg::BIT_ZERO;
               end
            end
            default:
               state_d.ackDrive = 1'h0; // Idle or ignoring transfer
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_q                <= '0;
         state_q.prev           <= '1;
         state_q.cfg.ldoMargin  <= i2cswp_pkg::MARGIN_NOMINAL;
         state_q.cfg.swMargin   <= i2cswp_pkg::MARGIN_NOMINAL;
         state_q.cfg.watchdog   <= i2cswp_pkg::WD_OFF;
         state_q.phase          <= i2cswp_pkg::I2CSWP_IDLE;
      end
      else if (enable)
         state_q <= state_d;
   end

   // Outputs straight from state flip-flops, except sdaOut, which is tied low
   assign sdaOut               = 1'h0;
   assign sdaOe                = state_q.ackDrive;
   assign oscillatorSyncPinOut = state_q.syncClk;
   assign oscillatorSyncPinOe  = state_q.syncOutMode;
   assign syncClockOut         = state_q.syncClk;
   assign cfgOut               = state_q.cfg;
endmodule : i2c_slave_write_port

// ==== tb/i2cswp_asserts.sv ====
module i2cswp_checker
(
   input wire logic                       clock,
   input wire logic                       sys_rst,
   input wire logic                       sclIn,
   input wire logic                       sdaOut,
   input wire logic                       sdaOe,
   input wire logic                       clockSelectStrap,
   input wire logic                       oscillatorSyncPinOe,
   input wire logic                       oscClockIn,
   input wire logic                       oscillatorSyncPinOut,
   input wire logic                       syncClockOut,
   input wire i2cswp_pkg::i2cswp_cfg_type cfgOut
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // Ack only ever pulls low
   a_ack_pulls_low: assert property (sdaOe |-> !sdaOut)
      else $error("ack drives high");
   // Ack starts inside the SCL low phase
   a_ack_scl_low: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("ack starts with SCL high");
   // Ack stands over the clock pulse
   a_ack_held: assert property ($rose(sdaOe) |-> sdaOe[*8])
      else $error("ack too short");
   a_ack_release: assert property ($rose(sdaOe) |-> ##[1:60] !sdaOe)
      else $error("ack never released");
   // Strap decides sync pin direction
   a_sync_dir: assert property (!$past(sys_rst, 3) |->
      oscillatorSyncPinOe == clockSelectStrap)
      else $error("sync pin direction wrong");
   // Sync clock lags its input by two sync stages and one register
   a_sync_follow: assert property (!$past(sys_rst, 3) |->
      syncClockOut == $past(oscClockIn, 3))
      else $error("sync clock does not follow input");
   a_pin_follow: assert property (!$past(sys_rst, 3) &&
      oscillatorSyncPinOe |-> oscillatorSyncPinOut == $past(oscClockIn, 3))
      else $error("sync pin output does not follow");
   a_strobe_pulse: assert property (cfgOut.strobe |=> !cfgOut.strobe)
      else $error("strobe longer than one cycle");
   // Settings move only with an applied command
   a_cfg_hold: assert property ($changed(cfgOut[13:1]) |-> cfgOut.strobe)
      else $error("settings changed without strobe");
   a_strobe_acked: assert property (cfgOut.strobe |-> ##[0:60] sdaOe)
      else $error("applied byte not acked");
   c_ack: cover property ($rose(sdaOe));
   c_apply: cover property (cfgOut.strobe);
   c_osc_out: cover property (oscillatorSyncPinOe);
endmodule : i2cswp_checker

bind i2c_slave_write_port i2cswp_checker u_chk (.clock(clock),
   .sys_rst(sys_rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .clockSelectStrap(clockSelectStrap), .cfgOut(cfgOut),
   .oscillatorSyncPinOe(oscillatorSyncPinOe), .oscClockIn(oscClockIn),
   .oscillatorSyncPinOut(oscillatorSyncPinOut),
   .syncClockOut(syncClockOut));

// ==== tb/i2cswp_master.sv ====
module i2cswp_master
(
   input  wire logic clock,
   input  wire logic sdaLine,
   output logic      sclOut,
   output logic      sdaLow
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus: SCL stands high, SDA released
   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   ////////////////////////////////////////
   // Quarter of the 160 ns link period
   task automatic qw;
      repeat (10) @(negedge clock);
   endtask : qw
   // SDA falls while SCL high; also serves as repeated start
   task automatic start_cond;
      sdaLow = 1'b0;
      qw;
      sclOut = 1'b1;
      qw;
      sdaLow = 1'b1;
      qw;
      sclOut = 1'b0;
      qw;
   endtask : start_cond
   task automatic stop_cond;
      sdaLow = 1'b1;
      qw;
      sclOut = 1'b1;
      qw;
      sdaLow = 1'b0;
      qw;
   endtask : stop_cond
   // MSB first, then release SDA and sample the ack mid-high
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sdaLow = !b[i];
         qw;
         sclOut = 1'b1;
         qw;
         qw;
         sclOut = 1'b0;
         qw;
      end
      sdaLow = 1'b0;
      qw;
      sclOut = 1'b1;
      qw;
      ack = !sdaLine;
      qw;
      sclOut = 1'b0;
      qw;
   endtask : send_byte
endmodule : i2cswp_master

// ==== tb/tb_i2c_slave_write_port.sv ====
module tb_i2c_slave_write_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 0;
   logic        sys_rst = 1;
   logic        selStrap = 0;
   logic        idStrap = 0;
   logic        oscIn = 0;
   logic        scl, mLow, sdaOe, sdaOut, pinOe, ack;
   logic [31:0] lfsr = 32'h04D2;
   int          fails = 0;
   int          samples_checked = 0;
   i2cswp_pkg::i2cswp_cfg_type cfgOut, exp;
   i2cswp_pkg::i2cswp_cfg_type notes[$];
   // Pull-up: a released line reads high
   wire sda = !(mLow | sdaOe);
   always #2 clock = ~clock;
   always @(negedge clock) oscIn <= ~oscIn;
   i2c_slave_write_port DUT (.clock(clock), .sys_rst(sys_rst),
      .enable(1'b1), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .clockSelectStrap(selStrap), .busIdStrap(idStrap),
      .oscClockIn(oscIn), .oscillatorSyncPinOut(),
      .oscillatorSyncPinOe(pinOe), .syncClockOut(), .cfgOut(cfgOut));
   i2cswp_master mst (.clock(clock), .sdaLine(sda), .sclOut(scl),
      .sdaLow(mLow));
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   // Next value of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic give_verdict;
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // Start plus address byte, ack compared
   task automatic addr(input logic [6:0] a, input logic rw, input logic w);
      mst.start_cond();
      mst.send_byte({a, rw}, ack);
      check(ack, w);
   endtask : addr
   // Data byte; the expected settings are noted before sending
   task automatic put(input logic [7:0] b, input logic apply);
      if (apply)
      begin
         if (b[7:5] == i2cswp_pkg::OP_MARGIN && b[4])
            exp.swMargin = b[3:0];
         else if (b[7:5] == i2cswp_pkg::OP_MARGIN)
            exp.ldoMargin = b[3:0];
         else
            exp.watchdog = b[4:0];
         exp.strobe = 1'b1;
         notes.push_back(exp);
         exp.strobe = 1'b0;
      end
      mst.send_byte(b, ack);
      check(ack, 1'b1);
   endtask : put
   // Oldest note against each applied command
   always @(negedge clock)
      if (cfgOut.strobe === 1'b1)
         check(32'(cfgOut), notes.size() ? 32'(notes.pop_front()) : '1);
   // Hang guard, well past the expected run
   initial
   begin
      #200000;
      fails++;
      give_verdict();
   end
   initial
   begin
      for (int s = 0; s < 4; s++)
      begin
         sys_rst = 1'b1;
         {selStrap, idStrap} = s[1:0];
         repeat (4) @(negedge clock);
         sys_rst = 1'b0;
         repeat (8) @(negedge clock);
         exp = '0;
         check(32'(cfgOut), 32'h0);
         check(pinOe, selStrap);
         for (int a = 0; a < 4; a++)
         begin
            addr({5'h1D, a[1:0]}, 1'b0, a == s);
            mst.stop_cond();
         end
         addr({5'h1C, s[1:0]}, 1'b0, 1'b0);
         mst.stop_cond();
         addr({5'h1D, s[1:0]}, 1'b1, 1'b0);
         mst.stop_cond();
         lfsr = lfsr_next(lfsr);
         addr({5'h1D, s[1:0]}, 1'b0, 1'b1);
         put(8'h20, 1'b0);
         put({4'h2, lfsr[3:0]}, 1'b1);
         put({4'h3, lfsr[7:4]}, 1'b1);
         // Repeated start disarms: a lone margin byte is ignored
         addr({5'h1D, s[1:0]}, 1'b0, 1'b1);
         put(8'h2F, 1'b0);
         put(8'h60, 1'b0);
         put({5'h0D, lfsr[10:8]}, 1'b1);
         mst.stop_cond();
         repeat (20) @(negedge clock);
         check(notes.size(), 32'h0);
         $display("test strap %0d done", s);
      end
      give_verdict();
   end
endmodule : tb_i2c_slave_write_port
